/* File: hw/ptr_pkg.sv */
// Purpose: Shared constants and carrier types of the page 2 trim and EEE bank.
// Assumes: Management register N sits at byte address 4*N on the AHB-Lite bus.
// Notes:   Only word transfers are honoured; all answers are OKAY.
package ptr_pkg;
   // Management register indices.
   localparam logic [4:0]  CTRL_IDX     = 5'h00;
   localparam logic [4:0]  STD_HI_IDX   = 5'h0F;
   localparam logic [4:0]  TRIM_IDX     = 5'h10;
   localparam logic [4:0]  EEE_IDX      = 5'h11;
   localparam logic [4:0]  PAGE2_LO_IDX = 5'h10;
   localparam logic [4:0]  PAGE2_HI_IDX = 5'h1E;
   localparam logic [4:0]  PAGE_IDX     = 5'h1F;
   // Page select codes and reset values.
   localparam logic [15:0] PAGE_STD     = 16'h0000;
   localparam logic [15:0] PAGE_EXT2    = 16'h0002;
   localparam logic [15:0] TRIM_RST     = 16'h02BE;
   localparam logic [11:0] EEE_RST      = 12'h000;
   localparam logic [1:0]  SPD_RST      = 2'h0;
   localparam logic [1:0]  SPD_GIG      = 2'h2;
   // Field positions of the standard control register.
   localparam int          CTRL_SRST_BIT = 15;
   localparam int          CTRL_SPDM_BIT = 6;
   localparam int          CTRL_SPDL_BIT = 13;
   // AHB-Lite codes and the LED idle pattern.
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   localparam logic        HRESP_OKAY   = 1'b0;
   localparam logic [7:0]  LED_OFF      = 8'hFF;

   // Transmit amplitude trim fields, one per copper speed.
   typedef struct packed {
      logic [3:0] gig;
      logic [3:0] fe;
      logic [3:0] ten;
      logic [3:0] ten_e;
   } ptr_trim_t;

   // EEE debug controls in register order, bit 9 and status bits left out.
   typedef struct packed {
      logic       en_10te;
      logic       led_unidir;
      logic [3:0] led_inv;
      logic       force_gig;
      logic       force_lpi;
      logic       inh_fe_tx;
      logic       inh_fe_rx;
      logic       inh_gig_tx;
      logic       inh_gig_rx;
   } ptr_eee_t;

   // Line-side levels that arrive from outside the clock domain.
   typedef struct packed {
      logic link_up;
      logic eee_gig;
      logic eee_fe;
      logic speed_gig;
      logic speed_fe;
      logic mac_lpi;
      logic line_lpi;
   } ptr_phy_in_t;

   // Registered controls driven into the datapath.
   typedef struct packed {
      logic line_tx_lpi;
      logic mac_rx_lpi;
      logic force_gig_nomaster;
      logic en_10te;
      logic led_unidir;
   } ptr_phy_out_t;

   // Whole state of the bank.
   typedef struct packed {
      logic         ap_valid;
      logic         ap_write;
      logic [4:0]   ap_idx;
      logic [15:0]  page;
      logic [1:0]   spd;
      ptr_trim_t    trim;
      ptr_eee_t     eee;
      ptr_phy_in_t  sync1;
      ptr_phy_in_t  sync2;
      logic [31:0]  rdata;
      ptr_phy_out_t out;
      logic [7:0]   led;
   } ptr_state_t;
endpackage

/* File: hw/ptr_page2_regs.sv */
// Purpose: Extended page 2 bank with transmit trim and EEE debug control.
// Assumes: One AHB-Lite master, zero wait states, inputs on pins synchronised.
// Notes:   Contract
// Contract
// R1 - Writing 0x0002 to register 31 selects page 2; device honours it.
// R2 - With page 2 selected, registers 16-30 reach the page 2 bank.
// R3 - Registers 0-15 decode to standard space whatever the page.
// R4 - Writing 0x0000 to register 31 returns 16-30 to standard space.
// R5 - Trim bits 15:12 gigabit amplitude, read-write, reset 0000.
// R6 - Trim bits 11:8 fast Ethernet amplitude, read-write, reset 0010.
// R7 - Trim bits 7:4 10 Mb/s amplitude, read-write, reset 1011.
// R8 - Trim bits 3:0 energy-efficient 10 Mb/s amplitude, reset 1110.
// R9 - EEE bit 15 sticky enable of energy-efficient 10 Mb/s mode.
// R10 - EEE bit 14 sticky, keeps LEDs working in fiber unidirectional mode.
// R11 - EEE bits 13:10 sticky LED polarity inversion, LEDs active low otherwise.
// R12 - Bits 8, 7, 6 read link up, gigabit EEE, fast Ethernet EEE.
// R13 - Bit 5 sticky, gigabit link without forced role when speed is 10; the code applies it only with speed select SPD_GIG (1000).
// R14 - Bit 4 sticky, sends LPI on the line and ignores MAC data.
// R15 - Bit 3 sticky, blocks line transmit LPI in fast Ethernet mode.
// R16 - Bit 2 sticky, blocks LPI towards MAC in fast Ethernet mode.
// R17 - Bit 1 sticky, blocks line transmit LPI in gigabit mode.
// R18 - Bit 0 sticky, blocks LPI towards MAC in gigabit mode.
// R19 - Software uses bits 4:0 only for debug, leaving defaults.
// R20 - Sticky bits survive software reset, cleared only by hardware reset.
// R21 - Reserved bit 9 reads zero and ignores writes.
`timescale 1ns/1ps
module ptr_page2_regs
   import ptr_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  ptr_phy_in_t      phy_in,
   input  wire logic        fiber_unidir,
   input  wire logic [7:0]  led_request,
   output ptr_trim_t        tx_trim,
   output ptr_phy_out_t     phy_out,
   output logic [7:0]       indicator_outputs
);

   ptr_state_t st_reg;
   ptr_state_t st_next;

   // True when an index is steered onto the page 2 bank.
   function automatic logic is_page2(input logic [4:0] idx, input logic [15:0] pg);
      is_page2 = (pg == PAGE_EXT2) && (idx >= PAGE2_LO_IDX) && (idx <= PAGE2_HI_IDX);
   endfunction

   logic        addr_take;
   logic        data_wr;
   logic [15:0] wdat;
   logic [15:0] rd_val;
   logic        spd_gig;
   logic        spd_fe;
   logic        led_hold;

   // Zero wait states, so the slave is always ready and always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = st_reg.rdata;
   assign tx_trim   = st_reg.trim;
   assign phy_out   = st_reg.out;
   assign indicator_outputs = st_reg.led;

   // Address phase accepted only for mapped word transfers.
   assign addr_take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD)
                      && (haddr[31:7] == 25'h0) && (haddr[1:0] == 2'h0);
   assign data_wr   = st_reg.ap_valid && st_reg.ap_write;
   assign wdat      = hwdata[15:0];
   assign spd_gig   = st_reg.sync2.speed_gig;
   assign spd_fe    = st_reg.sync2.speed_fe;
   assign led_hold  = fiber_unidir && !st_reg.eee.led_unidir; // R10

   // Read value of the index presented in the address phase.
   always_comb
   begin
      rd_val = 16'h0000;
      if (haddr[6:2] == PAGE_IDX)
      begin
         rd_val = st_reg.page;
      end
      else if (haddr[6:2] == CTRL_IDX) // R3
      begin
         rd_val[CTRL_SPDM_BIT] = st_reg.spd[1];
         rd_val[CTRL_SPDL_BIT] = st_reg.spd[0];
      end
      else if (is_page2(haddr[6:2], st_reg.page)) // R2
      begin
         if (haddr[6:2] == TRIM_IDX)
         begin
            rd_val = st_reg.trim;
         end
         else if (haddr[6:2] == EEE_IDX)
         begin
            rd_val = {st_reg.eee.en_10te, st_reg.eee.led_unidir,
                      st_reg.eee.led_inv, 1'b0, // R21
                      st_reg.sync2.link_up, st_reg.sync2.eee_gig,
                      st_reg.sync2.eee_fe, // R12
                      st_reg.eee.force_gig, st_reg.eee.force_lpi,
                      st_reg.eee.inh_fe_tx, st_reg.eee.inh_fe_rx,
                      st_reg.eee.inh_gig_tx, st_reg.eee.inh_gig_rx};
         end
      end
   end

   // Next state: bus phases, register writes, synchronisers and outputs.
   always_comb
   begin
      st_next          = st_reg;
      st_next.ap_valid = addr_take;
      st_next.ap_write = hwrite;
      st_next.ap_idx   = haddr[6:2];
      if (addr_take && !hwrite)
      begin
         st_next.rdata = {16'h0000, rd_val};
      end
      st_next.sync1 = phy_in;
      st_next.sync2 = st_reg.sync1;
      if (data_wr)
      begin
         if (st_reg.ap_idx == PAGE_IDX)
         begin
            st_next.page = wdat; // R1 R4
         end
         else if (st_reg.ap_idx == CTRL_IDX)
         begin
            st_next.spd = {wdat[CTRL_SPDM_BIT], wdat[CTRL_SPDL_BIT]};
            if (wdat[CTRL_SRST_BIT])
            begin
               // Software reset: plain fields go home, sticky EEE stays.
               st_next.spd  = SPD_RST;
               st_next.trim = TRIM_RST; // R5 R6 R7 R8
               st_next.page = PAGE_STD; // R20
            end
         end
         else if (is_page2(st_reg.ap_idx, st_reg.page))
         begin
            if (st_reg.ap_idx == TRIM_IDX)
            begin
               st_next.trim = wdat; // R5 R6 R7 R8
            end
            else if (st_reg.ap_idx == EEE_IDX)
            begin
               st_next.eee = {wdat[15:10], wdat[5:0]}; // R9 R11 R21
            end
         end
      end
      // LPI steering per speed mode.
      st_next.out.line_tx_lpi = st_reg.eee.force_lpi // R14
         || (st_reg.sync2.mac_lpi
             && !(spd_fe && st_reg.eee.inh_fe_tx) // R15
             && !(spd_gig && st_reg.eee.inh_gig_tx)); // R17
      st_next.out.mac_rx_lpi = st_reg.sync2.line_lpi
         && !(spd_fe && st_reg.eee.inh_fe_rx) // R16
         && !(spd_gig && st_reg.eee.inh_gig_rx); // R18
      st_next.out.force_gig_nomaster = st_reg.eee.force_gig && (st_reg.spd == SPD_GIG); // R13
      st_next.out.en_10te    = st_reg.eee.en_10te; // R9
      st_next.out.led_unidir = st_reg.eee.led_unidir;
      // LED pins idle high and drive low when lit, unless inverted.
      for (int i = 0; i < 8; i++)
      begin
         st_next.led[i] = (led_request[i] && !led_hold) ^ !st_reg.eee.led_inv[i % 4]; // R11
      end
   end

   // State register; hardware reset restores every field.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_reg       <= '0;
         st_reg.page  <= PAGE_STD;
         st_reg.spd   <= SPD_RST;
         st_reg.trim  <= TRIM_RST;
         st_reg.eee   <= EEE_RST; // R20
         st_reg.led   <= LED_OFF;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Data-phase write of one register with a given value.
   sequence s_wr(logic [4:0] idx, logic [15:0] val);
      data_wr && (st_reg.ap_idx == idx) && (wdat == val);
   endsequence

   // Address phase of a read of one register.
   sequence s_rd(logic [4:0] idx);
      addr_take && !hwrite && (haddr[6:2] == idx);
   endsequence

   chk_page_select: assert property (s_wr(PAGE_IDX, PAGE_EXT2) |=> st_reg.page == PAGE_EXT2) // R1
      else $error("Page select write not taken.");

   chk_page2_route: assert property ((s_rd(TRIM_IDX) ##0 (st_reg.page == PAGE_EXT2))
      |=> hrdata == {16'h0000, $past(st_reg.trim)}) // R2
      else $error("Page 2 read did not return trim.");

   chk_low_decode: assert property (s_rd(CTRL_IDX) |=> hrdata[CTRL_SPDM_BIT] == $past(st_reg.spd[1])) // R3
      else $error("Standard register read wrong under a page.");

   chk_page_back: assert property ((s_rd(TRIM_IDX) ##0 (st_reg.page == PAGE_STD))
      |=> hrdata == 32'h0) // R4
      else $error("Standard space read returned page 2 data.");

   chk_trim_srst: assert property (s_wr(CTRL_IDX, 16'h8000)
      |=> (st_reg.trim == TRIM_RST) && (st_reg.eee == $past(st_reg.eee))) // R20
      else $error("Software reset mishandled trim or sticky bits.");

   chk_rsvd_zero: assert property (s_rd(EEE_IDX) |=> hrdata[9] == 1'b0) // R21
      else $error("Reserved bit read as one.");

   chk_led_polar: assert property (##1 (indicator_outputs[0] ==
      (($past(led_request[0]) && !$past(led_hold)) ^ !$past(st_reg.eee.led_inv[0])))) // R11
      else $error("LED polarity wrong.");

   chk_tx_lpi_gate: assert property ((st_reg.sync2.mac_lpi && spd_gig && st_reg.eee.inh_gig_tx
      && !st_reg.eee.force_lpi) |=> !phy_out.line_tx_lpi) // R17
      else $error("Gigabit transmit LPI not inhibited.");

   chk_force_lpi: assert property (st_reg.eee.force_lpi |=> phy_out.line_tx_lpi) // R14
      else $error("Forced LPI not sent.");

   chk_force_gig: assert property ((st_reg.eee.force_gig && st_reg.spd == SPD_GIG)
      |=> phy_out.force_gig_nomaster) // R13
      else $error("Gigabit force mode not applied.");

   chk_status_rd: assert property ((s_rd(EEE_IDX) ##0 (st_reg.page == PAGE_EXT2))
      |=> hrdata[8] == $past(st_reg.sync2.link_up)) // R12
      else $error("Link status bit wrong.");

   chk_fe_tx_gate: assert property ((st_reg.sync2.mac_lpi && spd_fe && st_reg.eee.inh_fe_tx
      && !st_reg.eee.force_lpi) |=> !phy_out.line_tx_lpi) // R15
      else $error("Fast Ethernet transmit LPI not inhibited.");

   chk_fe_rx_gate: assert property ((st_reg.sync2.line_lpi && spd_fe && st_reg.eee.inh_fe_rx)
      |=> !phy_out.mac_rx_lpi) // R16
      else $error("Fast Ethernet receive LPI not inhibited.");

   chk_gig_rx_gate: assert property ((st_reg.sync2.line_lpi && spd_gig && st_reg.eee.inh_gig_rx)
      |=> !phy_out.mac_rx_lpi) // R18
      else $error("Gigabit receive LPI not inhibited.");

   chk_ten_e_out: assert property (st_reg.eee.en_10te |=> phy_out.en_10te) // R9
      else $error("Energy-efficient 10 Mb/s mode not enabled.");

   chk_led_unidir: assert property ((fiber_unidir && st_reg.eee.led_unidir)
      |=> indicator_outputs[0] == ($past(led_request[0]) ^ !$past(st_reg.eee.led_inv[0]))) // R10
      else $error("LED held in fiber unidirectional mode.");

endmodule

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the page 2 trim and EEE bank.
// Assumes: Zero wait state slave, hready follows hreadyout.
// Notes:   Register N sits at byte address four times N.
`timescale 1ns/1ps
module tb_top
   import ptr_pkg::*;
;
   logic         hclk = 1'b0;
   logic         hresetn = 1'b0;
   logic         hsel = 1'b0;
   logic [31:0]  haddr = 32'h0;
   logic [1:0]   htrans = 2'h0;
   logic         hwrite = 1'b0;
   logic [2:0]   hsize = 3'h2;
   logic [31:0]  hwdata = 32'h0;
   logic         hreadyout;
   logic         hresp;
   logic [31:0]  hrdata;
   ptr_phy_in_t  phy_in = '0;
   logic         fiber_unidir = 1'b0;
   logic [7:0]   led_request = 8'h00;
   ptr_trim_t    tx_trim;
   ptr_phy_out_t phy_out;
   logic [7:0]   indicator_outputs;
   int           error_cnt = 0;
   int           cmp_count = 0;
   logic [31:0]  rd;
   // Control word, line inputs and expected datapath controls per case.
   logic [15:0]  eee_tab [7] = '{16'h0000, 16'h000C, 16'h0003, 16'h000C, 16'h0013, 16'hC000, 16'h0020};
   logic [6:0]   in_tab [7] = '{7'h07, 7'h07, 7'h0B, 7'h0B, 7'h0B, 7'h07, 7'h07};
   logic [4:0]   out_tab [7] = '{5'h18, 5'h00, 5'h00, 5'h18, 5'h10, 5'h1B, 5'h1C};

   // Clock at 20 MHz.
   always #25 hclk = ~hclk;

   // Device under test; hready is the slave's own hreadyout.
   ptr_page2_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phy_in(phy_in),
      .fiber_unidir(fiber_unidir), .led_request(led_request), .tx_trim(tx_trim),
      .phy_out(phy_out), .indicator_outputs(indicator_outputs));

   // Compares a seen value with the expected one and counts the result.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One single word transfer; entered just after a rising edge.
   task automatic bus(input logic [4:0] idx, input logic w, input logic [15:0] wd);
      hsel <= 1'b1;
      haddr <= {25'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {16'hFFFF, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [4:0] idx, input logic [15:0] v);
      bus(idx, 1'b1, v);
   endtask

   task automatic rdchk(input string what, input logic [4:0] idx, input logic [15:0] exp);
      bus(idx, 1'b0, 16'h0000);
      check(what, rd, {16'h0000, exp});
   endtask

   // Lets synchronisers and output registers catch up.
   task automatic settle();
      repeat (5) @(posedge hclk);
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   // Expected pin levels: active low unless the matching bit inverts them.
   function automatic logic [7:0] exp_led(input logic [7:0] req, input logic [3:0] inv,
                                          input logic hold);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = (req[i] & ~hold) ^ ~inv[i % 4];
      return r;
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence of tests.
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("trim out reset", {16'h0, tx_trim}, 32'h02BE);
      check("led reset", {24'h0, indicator_outputs}, 32'hFF);
      check("ready okay", {30'h0, hreadyout, hresp}, 32'h2);
      rdchk("std reg16", TRIM_IDX, 16'h0000);
      wr(PAGE_IDX, PAGE_EXT2);
      rdchk("page select", PAGE_IDX, PAGE_EXT2);
      rdchk("trim default", TRIM_IDX, TRIM_RST);
      wr(TRIM_IDX, 16'h8F71);
      rdchk("trim rw", TRIM_IDX, 16'h8F71);
      check("trim out", {16'h0, tx_trim}, 32'h8F71);
      rdchk("eee default", EEE_IDX, 16'h0000);
      wr(EEE_IDX, 16'hFFFF);
      rdchk("eee rw", EEE_IDX, 16'hFC3F);
      rdchk("unmapped", 5'h12, 16'h0000);
      wr(CTRL_IDX, 16'h0040);
      rdchk("ctrl on page 2", CTRL_IDX, 16'h0040);
      done("registers");
      for (int k = 0; k < 7; k++)
      begin
         wr(EEE_IDX, eee_tab[k]);
         phy_in <= ptr_phy_in_t'(in_tab[k]);
         settle();
         check("phy_out", {27'h0, phy_out}, {27'h0, out_tab[k]});
      end
      phy_in <= ptr_phy_in_t'(7'h70);
      settle();
      rdchk("status", EEE_IDX, 16'h01E0);
      done("lpi and status");
      wr(EEE_IDX, 16'h1400);
      led_request <= 8'h0F;
      settle();
      check("led inv", {24'h0, indicator_outputs}, {24'h0, exp_led(8'h0F, 4'h5, 1'b0)});
      fiber_unidir <= 1'b1;
      settle();
      check("led unidir", {24'h0, indicator_outputs}, {24'h0, exp_led(8'h0F, 4'h5, 1'b1)});
      wr(EEE_IDX, 16'h5400);
      settle();
      check("led kept", {24'h0, indicator_outputs}, {24'h0, exp_led(8'h0F, 4'h5, 1'b0)});
      done("leds");
      wr(CTRL_IDX, 16'h8000);
      rdchk("page after srst", EEE_IDX, 16'h0000);
      wr(PAGE_IDX, PAGE_EXT2);
      rdchk("eee sticky", EEE_IDX, 16'h55C0);
      rdchk("trim srst", TRIM_IDX, TRIM_RST);
      rdchk("ctrl srst", CTRL_IDX, 16'h0000);
      wr(PAGE_IDX, PAGE_STD);
      rdchk("std again", EEE_IDX, 16'h0000);
      phy_in <= '0;
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      wr(PAGE_IDX, PAGE_EXT2);
      rdchk("eee hw reset", EEE_IDX, 16'h0000);
      done("resets");
      end_of_test();
   end

   // Cuts a hang short well after the tests should have ended.
   initial
   begin
      #(50 * 20000);
      error_cnt++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule
